// ---- logic/t2c_pkg.sv ----
// constants for the capture/reload timer block
package t2c_pkg;
  // register addresses on the special-function bus
  localparam logic [7:0] ADDR_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_MODE = 8'hc9;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
  // timer_control field positions
  localparam int CTL_OVERFLOW = 7;
  localparam int CTL_EXT_FLAG = 6;
  localparam int CTL_RX_BAUD = 5;
  localparam int CTL_TX_BAUD = 4;
  localparam int CTL_TRIG_EN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_COUNT_SRC = 1;
  localparam int CTL_CAPTURE = 0;
  // timer_mode field positions
  localparam int MODE_UPDOWN = 0;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [0:0] MODE_RESET = 1'h0;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  // internal timing clock: core clocks per count step
  localparam int TIMER_DIV = 12;
  localparam int BAUD_DIV = 2;
endpackage

// ---- logic/t2c_pin_edge.sv ----
// two-flop pin synchroniser with falling edge pulse
`timescale 1ns/100ps
`default_nettype none
module t2c_pin_edge (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // pins idle high through pull-ups, so reset to one avoids a false edge
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign fall = last_ff & ~sync_ff;
endmodule
`default_nettype wire

// ---- logic/t2c_timer.sv ----
// capture/reload timer: registers, counter, flags and baud clock select
`timescale 1ns/100ps
`default_nettype none
module t2c_timer (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic trigger_pin,
  input wire logic external_count_input,
  input wire logic timer1_overflow,
  input wire logic timer_irq_enable,
  output logic timer_irq,
  output logic rx_baud_clk,
  output logic tx_baud_clk
);
  localparam int DIV_W = $clog2(t2c_pkg::TIMER_DIV);

  logic [7:0] control_ff;
  logic [0:0] mode_ff;
  logic [15:0] reload_ff;
  logic [15:0] count_ff;
  logic [DIV_W-1:0] div_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic rx_clk_ff;
  logic tx_clk_ff;

  logic trig_level;
  logic trig_fall;
  logic ext_fall;

  logic baud_mode;
  logic updown;
  logic tick;
  logic count_step;
  logic count_up;
  logic overflow;
  logic trig_event;
  logic reload_mode;
  logic [DIV_W-1:0] div_last;
  logic [15:0] nxt_count;
  logic wr_control;
  logic wr_mode;
  logic wr_rel_lo;
  logic wr_rel_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;

  function automatic logic hit(input logic strobe, input logic [7:0] a,
                               input logic [7:0] target);
    hit = strobe && (a == target);
  endfunction

  t2c_pin_edge u_trigger (
    .mclk(mclk),
    .resetn(resetn),
    .pin(trigger_pin),
    .level(trig_level),
    .fall(trig_fall)
  );

  t2c_pin_edge u_count_pin (
    .mclk(mclk),
    .resetn(resetn),
    .pin(external_count_input),
    .level(),
    .fall(ext_fall)
  );

  assign wr_control = hit(bus_wr, bus_addr, t2c_pkg::ADDR_CONTROL);
  assign wr_mode = hit(bus_wr, bus_addr, t2c_pkg::ADDR_MODE);
  assign wr_rel_lo = hit(bus_wr, bus_addr, t2c_pkg::ADDR_RELOAD_LOW);
  assign wr_rel_hi = hit(bus_wr, bus_addr, t2c_pkg::ADDR_RELOAD_HIGH);
  assign wr_cnt_lo = hit(bus_wr, bus_addr, t2c_pkg::ADDR_COUNT_LOW);
  assign wr_cnt_hi = hit(bus_wr, bus_addr, t2c_pkg::ADDR_COUNT_HIGH);

  assign baud_mode = control_ff[t2c_pkg::CTL_RX_BAUD] |
                     control_ff[t2c_pkg::CTL_TX_BAUD];
  assign updown = mode_ff[t2c_pkg::MODE_UPDOWN];
  // direction only matters in up/down mode; pin high counts up
  assign count_up = ~updown | trig_level;

  // baud use runs the tick faster, as the serial port expects
  assign div_last = baud_mode ? DIV_W'(t2c_pkg::BAUD_DIV - 1)
                              : DIV_W'(t2c_pkg::TIMER_DIV - 1);
  assign tick = (div_ff >= div_last);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      div_ff <= '0;
    else if (tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + DIV_W'(1);
  end

  // external source counts synchronised falling edges only
  assign count_step = control_ff[t2c_pkg::CTL_RUN] &
    (control_ff[t2c_pkg::CTL_COUNT_SRC] ? ext_fall : tick);

  // up: roll from all ones; down: step past the reload value
  assign overflow = count_step &
    (count_up ? (count_ff == t2c_pkg::COUNT_ALL_ONES)
              : (count_ff == reload_ff));

  // in up/down mode the trigger pin steers direction instead
  assign trig_event = trig_fall & control_ff[t2c_pkg::CTL_TRIG_EN] &
                      ~baud_mode & ~updown;
  assign reload_mode = ~control_ff[t2c_pkg::CTL_CAPTURE] |
                       baud_mode;

  always_comb
  begin
    nxt_count = count_ff;
    if (reload_mode && (overflow || trig_event))
      nxt_count = count_up ? reload_ff
                           : t2c_pkg::COUNT_ALL_ONES;
    else if (overflow)
      nxt_count = count_up ? 16'h0000 : t2c_pkg::COUNT_ALL_ONES;
    else if (count_step)
      nxt_count = count_up ? count_ff + 16'h0001 : count_ff - 16'h0001;
    // a software write to a count byte wins over counting
    if (wr_cnt_lo)
      nxt_count[7:0] = bus_wdata;
    if (wr_cnt_hi)
      nxt_count[15:8] = bus_wdata;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      count_ff <= t2c_pkg::COUNT_RESET;
    else
      count_ff <= nxt_count;
  end

  // a software write to the pair wins over a capture in the same cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reload_ff <= t2c_pkg::RELOAD_RESET;
    else
    begin
      if (trig_event && !reload_mode)
        reload_ff <= count_ff;
      if (wr_rel_lo)
        reload_ff[7:0] <= bus_wdata;
      if (wr_rel_hi)
        reload_ff[15:8] <= bus_wdata;
    end
  end

  // byte writes come from the core's read-modify-write of single bits
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      control_ff <= t2c_pkg::CONTROL_RESET;
    else
    begin
      if (wr_control)
        control_ff <= bus_wdata;
      // a set in the same cycle as a clearing write is kept
      if (overflow && !baud_mode)
        control_ff[t2c_pkg::CTL_OVERFLOW] <= 1'b1;
      if (trig_event)
        control_ff[t2c_pkg::CTL_EXT_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      mode_ff <= t2c_pkg::MODE_RESET;
    else if (wr_mode)
      mode_ff <= bus_wdata[t2c_pkg::MODE_UPDOWN];
  end

  // unmapped addresses and unused bits read zero
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= 8'h00;
    else if (bus_rd)
    begin
      unique case (bus_addr)
        t2c_pkg::ADDR_CONTROL: rdata_ff <= control_ff;
        t2c_pkg::ADDR_MODE: rdata_ff <= {7'h00, mode_ff};
        t2c_pkg::ADDR_RELOAD_LOW: rdata_ff <= reload_ff[7:0];
        t2c_pkg::ADDR_RELOAD_HIGH: rdata_ff <= reload_ff[15:8];
        t2c_pkg::ADDR_COUNT_LOW: rdata_ff <= count_ff[7:0];
        t2c_pkg::ADDR_COUNT_HIGH: rdata_ff <= count_ff[15:8];
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= timer_irq_enable &
        (control_ff[t2c_pkg::CTL_OVERFLOW] |
         (control_ff[t2c_pkg::CTL_EXT_FLAG] & ~updown));
  end

  // serial port applies these only in its modes 1 and 3
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_clk_ff <= 1'b0;
      tx_clk_ff <= 1'b0;
    end
    else
    begin
      rx_clk_ff <= control_ff[t2c_pkg::CTL_RX_BAUD] ?
                   overflow : timer1_overflow;
      tx_clk_ff <= control_ff[t2c_pkg::CTL_TX_BAUD] ?
                   overflow : timer1_overflow;
    end
  end

  assign bus_rdata = rdata_ff;
  assign timer_irq = irq_ff;
  assign rx_baud_clk = rx_clk_ff;
  assign tx_baud_clk = tx_clk_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_trig_capture;
    trig_event && !reload_mode;
  endsequence

  a_flag_on_overflow: assert property (
    overflow && !baud_mode |=> control_ff[t2c_pkg::CTL_OVERFLOW])
    else $error("overflow flag not set after overflow");

  a_flag_sticky: assert property (
    control_ff[t2c_pkg::CTL_OVERFLOW] && !wr_control
    |=> control_ff[t2c_pkg::CTL_OVERFLOW])
    else $error("overflow flag cleared without a write");

  a_baud_no_flag: assert property (
    baud_mode && !control_ff[t2c_pkg::CTL_OVERFLOW] && !wr_control
    |=> !control_ff[t2c_pkg::CTL_OVERFLOW])
    else $error("overflow flag set in baud mode");

  a_trig_flag: assert property (
    trig_event |=> control_ff[t2c_pkg::CTL_EXT_FLAG])
    else $error("trigger flag not set after trigger event");

  a_irq_follows: assert property (
    timer_irq_enable && control_ff[t2c_pkg::CTL_EXT_FLAG] && !updown
    |=> timer_irq)
    else $error("trigger flag gave no interrupt");

  a_updown_noirq: assert property (
    !control_ff[t2c_pkg::CTL_OVERFLOW] && updown |=> !timer_irq)
    else $error("interrupt from trigger flag in up/down mode");

  a_rx_source: assert property (
    control_ff[t2c_pkg::CTL_RX_BAUD] |=> rx_baud_clk == $past(overflow))
    else $error("receive baud clock not from overflow");

  a_tx_source: assert property (
    !control_ff[t2c_pkg::CTL_TX_BAUD] |=>
      tx_baud_clk == $past(timer1_overflow))
    else $error("transmit baud clock not from timer 1");

  a_stopped_hold: assert property (
    !control_ff[t2c_pkg::CTL_RUN] && !wr_cnt_lo && !wr_cnt_hi &&
    !trig_event |=> $stable(count_ff))
    else $error("count moved while stopped");

  a_capture_value: assert property (
    s_trig_capture ##0 (!wr_rel_lo && !wr_rel_hi)
    |=> reload_ff == $past(count_ff))
    else $error("capture did not store the count");

  a_reload_copy: assert property (
    reload_mode && overflow && count_up && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == $past(reload_ff))
    else $error("reload did not copy the pair");

  a_capture_wrap: assert property (
    !reload_mode && overflow && count_up && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == 16'h0000)
    else $error("capture mode did not wrap to zero");

  a_baud_reload: assert property (
    baud_mode && overflow && count_up && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == $past(reload_ff))
    else $error("baud mode did not reload on overflow");

  a_ext_sticky: assert property (
    control_ff[t2c_pkg::CTL_EXT_FLAG] && !wr_control
    |=> control_ff[t2c_pkg::CTL_EXT_FLAG])
    else $error("trigger flag cleared without a write");

  a_trig_ignored: assert property (
    trig_fall && !control_ff[t2c_pkg::CTL_TRIG_EN] && !wr_control &&
    !control_ff[t2c_pkg::CTL_EXT_FLAG]
    |=> !control_ff[t2c_pkg::CTL_EXT_FLAG])
    else $error("trigger flag set while trigger disabled");

  a_tick_counts: assert property (
    control_ff[t2c_pkg::CTL_RUN] && !control_ff[t2c_pkg::CTL_COUNT_SRC] &&
    tick && count_up && !overflow && !trig_event && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("count did not step on the internal tick");

  a_pin_only: assert property (
    control_ff[t2c_pkg::CTL_COUNT_SRC] && !ext_fall && !trig_event &&
    !wr_cnt_lo && !wr_cnt_hi |=> $stable(count_ff))
    else $error("count moved without a pin edge");

  a_down_step: assert property (
    updown && !trig_level && count_step && !overflow &&
    !wr_cnt_lo && !wr_cnt_hi |=> count_ff == $past(count_ff) - 16'h0001)
    else $error("count did not step down");
endmodule
`default_nettype wire

// ---- dv/t2c_pins_model.sv ----
// pin-side model: trigger and external count pins of the port
`timescale 1ns/100ps
`default_nettype none
module t2c_pins_model (
  input wire logic mclk,
  output logic trigger_pin,
  output logic external_count_input
);
  // both pins have pull-ups, so they idle high outside pulses
  initial
  begin
    trigger_pin = 1'b1;
    external_count_input = 1'b1;
  end
  // levels held 3 clocks: the synchroniser needs at least 1
  task automatic pulse(input bit ext);
    @(posedge mclk);
    if (ext)
      external_count_input <= 1'b0;
    else
      trigger_pin <= 1'b0;
    repeat (3) @(posedge mclk);
    external_count_input <= 1'b1;
    trigger_pin <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // holds the trigger level, low selects counting down in up/down mode
  task automatic drive_trigger(input bit lvl);
    @(posedge mclk);
    trigger_pin <= lvl;
    repeat (3) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- dv/t2c_timer_test.sv ----
// self-checking bench for the capture/reload timer
`timescale 1ns/100ps
`default_nettype none
module t2c_timer_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic timer1_overflow = 1'b0;
  logic timer_irq_enable = 1'b0;
  logic [7:0] bus_rdata, d;
  logic trigger_pin, external_count_input;
  logic timer_irq, rx_baud_clk, tx_baud_clk;
  logic [15:0] v, w, c;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int rx_n = 0;
  int tx_n = 0;
  int t1_n = 0;
  int n;

  t2c_timer t2c_timer_i (
    .mclk(mclk),
    .resetn(resetn),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .trigger_pin(trigger_pin),
    .external_count_input(external_count_input),
    .timer1_overflow(timer1_overflow),
    .timer_irq_enable(timer_irq_enable),
    .timer_irq(timer_irq),
    .rx_baud_clk(rx_baud_clk),
    .tx_baud_clk(tx_baud_clk)
  );

  t2c_pins_model t2c_pins_model_i (
    .mclk(mclk),
    .trigger_pin(trigger_pin),
    .external_count_input(external_count_input)
  );

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // pulse counters, and the hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (rx_baud_clk === 1'b1) rx_n++;
    if (tx_baud_clk === 1'b1) tx_n++;
    if (timer1_overflow === 1'b1) t1_n++;
    if (cycles == 5000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, dd);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= dd;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 q = bus_rdata;
  endtask

  task automatic w16(input logic [7:0] a, input logic [15:0] x);
    wr(a, x[7:0]);
    wr(a + 8'h01, x[15:8]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] x);
    rd(a, x[7:0]);
    rd(a + 8'h01, x[15:8]);
  endtask

  task automatic ctl(input logic [7:0] x);
    wr(t2c_pkg::ADDR_CONTROL, x);
  endtask

  task automatic zero_counts();
    #1 rx_n = 0;
    tx_n = 0;
    t1_n = 0;
  endtask

  initial
  begin
    void'($urandom(32'h325c7012));
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 32'hc7; i <= 32'hce; i++)
    begin
      rd(8'(i), d);
      chk("reset value", 16'(d), 16'h0000);
    end
    v = 16'($urandom);
    w16(t2c_pkg::ADDR_RELOAD_LOW, v);
    rd16(t2c_pkg::ADDR_RELOAD_LOW, c);
    chk("reload pair", c, v);
    // capture on a trigger edge, flag raises the interrupt
    v = 16'($urandom);
    w16(t2c_pkg::ADDR_COUNT_LOW, v);
    timer_irq_enable <= 1'b1;
    ctl(8'h09);
    t2c_pins_model_i.pulse(1'b0);
    rd16(t2c_pkg::ADDR_RELOAD_LOW, c);
    chk("capture", c, v);
    rd(t2c_pkg::ADDR_CONTROL, d);
    chk("trigger flag", 16'(d), 16'h0049);
    chk("irq ext", 16'(timer_irq), 16'h0001);
    wr(t2c_pkg::ADDR_MODE, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk("irq updown", 16'(timer_irq), 16'h0000);
    wr(t2c_pkg::ADDR_MODE, 8'h00);
    // trigger ignored while its enable is clear
    w = 16'($urandom);
    w16(t2c_pkg::ADDR_COUNT_LOW, w);
    ctl(8'h01);
    t2c_pins_model_i.pulse(1'b0);
    rd16(t2c_pkg::ADDR_RELOAD_LOW, c);
    chk("no capture", c, v);
    rd(t2c_pkg::ADDR_CONTROL, d);
    chk("no flag", 16'(d), 16'h0001);
    // trigger reload in reload mode
    ctl(8'h08);
    t2c_pins_model_i.pulse(1'b0);
    rd16(t2c_pkg::ADDR_COUNT_LOW, c);
    chk("trigger reload", c, v);
    // overflow from all ones reloads and sets the flag
    w = 16'($urandom) & 16'h7fff;
    w16(t2c_pkg::ADDR_RELOAD_LOW, w);
    w16(t2c_pkg::ADDR_COUNT_LOW, 16'hffff);
    ctl(8'h04);
    repeat (20) @(posedge mclk);
    rd(t2c_pkg::ADDR_CONTROL, d);
    chk("overflow flag", 16'(d), 16'h0084);
    ctl(8'h80);
    rd16(t2c_pkg::ADDR_COUNT_LOW, c);
    // 24 run cycles hold exactly two ticks: reload, then one step
    chk("overflow reload", c, w + 16'h0001);
    chk("irq overflow", 16'(timer_irq), 16'h0001);
    repeat (30) @(posedge mclk);
    rd16(t2c_pkg::ADDR_COUNT_LOW, v);
    chk("stopped", v, c);
    ctl(8'h00);
    repeat (2) @(posedge mclk);
    #1 chk("irq cleared", 16'(timer_irq), 16'h0000);
    // capture mode wraps to zero, then steps once
    w16(t2c_pkg::ADDR_COUNT_LOW, 16'hffff);
    ctl(8'h05);
    repeat (22) @(posedge mclk);
    ctl(8'h00);
    rd16(t2c_pkg::ADDR_COUNT_LOW, c);
    chk("capture wrap", c, 16'h0001);
    // up/down mode, trigger low: count down, wrap past the reload value
    w = 16'($urandom) & 16'h7fff;
    w16(t2c_pkg::ADDR_RELOAD_LOW, w);
    w16(t2c_pkg::ADDR_COUNT_LOW, w + 16'h0001);
    wr(t2c_pkg::ADDR_MODE, 8'h01);
    t2c_pins_model_i.drive_trigger(1'b0);
    ctl(8'h04);
    repeat (22) @(posedge mclk);
    ctl(8'h00);
    rd16(t2c_pkg::ADDR_COUNT_LOW, c);
    chk("down wrap", c, 16'hffff);
    t2c_pins_model_i.drive_trigger(1'b1);
    wr(t2c_pkg::ADDR_MODE, 8'h00);
    // external pin counting
    w16(t2c_pkg::ADDR_COUNT_LOW, 16'h0000);
    ctl(8'h06);
    n = 1 + $urandom % 6;
    repeat (n) t2c_pins_model_i.pulse(1'b1);
    ctl(8'h00);
    rd16(t2c_pkg::ADDR_COUNT_LOW, c);
    chk("pin count", c, 16'(n));
    // transmit clock from timer 1, receive from the stopped timer
    ctl(8'h20);
    zero_counts();
    repeat (40)
    begin
      @(posedge mclk);
      timer1_overflow <= 1'($urandom);
    end
    @(posedge mclk);
    timer1_overflow <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("tx from timer1", 16'(tx_n), 16'(t1_n));
    chk("rx idle", 16'(rx_n), 16'h0000);
    // both baud clocks from this timer, capture select overridden
    w16(t2c_pkg::ADDR_RELOAD_LOW, 16'hfffe);
    w16(t2c_pkg::ADDR_COUNT_LOW, 16'hfffe);
    ctl(8'h3d);
    zero_counts();
    t2c_pins_model_i.pulse(1'b0);
    repeat (30) @(posedge mclk);
    rd(t2c_pkg::ADDR_CONTROL, d);
    chk("baud flags", 16'(d), 16'h003d);
    ctl(8'h00);
    chk("baud rx", 16'(rx_n >= 8), 16'h0001);
    chk("baud tx", 16'(tx_n), 16'(rx_n));
    end_of_test();
  end
endmodule
`default_nettype wire
